// ==== hw/srpfb_dev.sv ====
// Device end: serial slave, working registers and flash backup store
`timescale 1ns/1ns
module srpfb_dev
    import srpfb_pkg::*;
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Serial link
    srpfb_link_if.dev link,
    // User side status
    output logic cfg_loaded_out,
    output logic flash_busy_out,
    output logic cmd_strobe_out,
    output logic [7:0] cmd_byte_out
);
    typedef enum logic [1:0] {ST_LOAD, ST_RUN, ST_SAVE} srpfb_dstate_t;

    logic [2:0] sy1_reg, sy2_reg, sy3_reg, flt_reg;
    logic [2:0] sy1_next, sy2_next, sy3_next, flt_next;
    logic [15:0] rx_reg, rx_next, tx_reg, tx_next;
    logic [3:0] cnt_reg, cnt_next;
    logic miso_reg, miso_next, oe_n_reg, oe_n_next;
    srpfb_dstate_t st_reg, st_next;
    logic [5:0] idx_reg, idx_next;
    logic loaded_reg, loaded_next, strobe_reg, strobe_next, busy_reg, busy_next;
    logic [7:0] cbyte_reg, cbyte_next;
    logic [15:0] work_mem [NUM_REGS];
    // Erased flash at power-up; contents then survive every reset
    logic [15:0] flash_mem [NUM_REGS] = '{default: 16'h0000};
    logic work_we, flash_we;
    logic [5:0] work_wa, flash_wa;
    logic [15:0] work_wd, flash_wd;
    logic sel, rise, fall;
    logic [15:0] fw;
    logic [6:0] faddr;

    // Pin filter: a change counts once second and third stages agree
    always_comb
    begin
        sy1_next = {link.mosi, link.cs_n, link.sclk};
        sy2_next = sy1_reg;
        sy3_next = sy2_reg;
        for (int i = 0; i < 3; i++)
        begin
            flt_next[i] = (sy2_reg[i] == sy3_reg[i]) ? sy3_reg[i] : flt_reg[i];
        end
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            sy1_reg <= PIN_IDLE;
            sy2_reg <= PIN_IDLE;
            sy3_reg <= PIN_IDLE;
            flt_reg <= PIN_IDLE;
        end
        else
        begin
            sy1_reg <= sy1_next;
            sy2_reg <= sy2_next;
            sy3_reg <= sy3_next;
            flt_reg <= flt_next;
        end
    end

    assign sel = ~flt_next[PIN_CS];
    assign rise = flt_next[PIN_SCLK] & ~flt_reg[PIN_SCLK];
    assign fall = ~flt_next[PIN_SCLK] & flt_reg[PIN_SCLK];
    assign fw = {rx_reg[14:0], flt_next[PIN_DATA]};
    assign faddr = fw[ADDR_MSB:ADDR_LSB];

    // Shifting, frame decode and the load/save sequencer
    always_comb
    begin
        rx_next = rx_reg;
        tx_next = tx_reg;
        cnt_next = cnt_reg;
        miso_next = miso_reg;
        oe_n_next = ~sel;
        st_next = st_reg;
        idx_next = idx_reg;
        loaded_next = loaded_reg;
        strobe_next = 1'b0;
        cbyte_next = cbyte_reg;
        work_we = 1'b0;
        work_wa = idx_reg;
        work_wd = flash_mem[idx_reg];
        flash_we = 1'b0;
        flash_wa = idx_reg;
        flash_wd = work_mem[idx_reg];
        if (!sel)
        begin
            cnt_next = 4'h0;
        end
        else
        begin
            if (fall)
            begin
                miso_next = tx_reg[15];
                tx_next = {tx_reg[14:0], 1'b0};
            end
            if (rise)
            begin
                rx_next = fw;
                cnt_next = cnt_reg + 4'h1;
                if (cnt_reg == 4'(FRAME_BITS - 1))
                begin
                    cnt_next = 4'h0;
                    if (st_reg != ST_RUN)
                    begin
                        tx_next = BUSY_WORD;
                    end
                    else if (!fw[DIR_BIT])
                    begin
                        // Whole register whichever byte address was named
                        tx_next = work_mem[faddr[6:1]];
                    end
                    else if (faddr == CMD_ADDR)
                    begin
                        strobe_next = 1'b1;
                        cbyte_next = fw[DATA_MSB:0];
                        if (fw[FLASH_UPD_BIT])
                        begin
                            // Count the flash write, then copy it with the rest
                            work_we = 1'b1;
                            work_wa = FLASH_CNT_REG;
                            work_wd = work_mem[FLASH_CNT_REG] + 16'h0001;
                            st_next = ST_SAVE;
                            idx_next = 6'h00;
                        end
                    end
                    else
                    begin
                        work_we = 1'b1;
                        work_wa = faddr[6:1];
                        work_wd = work_mem[faddr[6:1]];
                        if (faddr[0])
                        begin
                            work_wd[15:8] = fw[DATA_MSB:0];
                        end
                        else
                        begin
                            work_wd[7:0] = fw[DATA_MSB:0];
                        end
                    end
                end
            end
        end
        unique case (st_reg)
            ST_LOAD:
            begin
                work_we = FLASH_BACKUP_MASK[idx_reg];
                idx_next = idx_reg + 6'h01;
                if (idx_reg == 6'(NUM_REGS - 1))
                begin
                    st_next = ST_RUN;
                    loaded_next = 1'b1;
                end
            end
            ST_SAVE:
            begin
                flash_we = FLASH_BACKUP_MASK[idx_reg];
                idx_next = idx_reg + 6'h01;
                if (idx_reg == 6'(NUM_REGS - 1))
                begin
                    st_next = ST_RUN;
                end
            end
            ST_RUN:
            begin
            end
        endcase
        busy_next = (st_next != ST_RUN);
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            rx_reg <= 16'h0000;
            tx_reg <= 16'h0000;
            cnt_reg <= 4'h0;
            miso_reg <= 1'b0;
            oe_n_reg <= 1'b1;
            st_reg <= ST_LOAD;
            idx_reg <= 6'h00;
            loaded_reg <= 1'b0;
            strobe_reg <= 1'b0;
            cbyte_reg <= 8'h00;
            busy_reg <= 1'b1;
        end
        else
        begin
            rx_reg <= rx_next;
            tx_reg <= tx_next;
            cnt_reg <= cnt_next;
            miso_reg <= miso_next;
            oe_n_reg <= oe_n_next;
            st_reg <= st_next;
            idx_reg <= idx_next;
            loaded_reg <= loaded_next;
            strobe_reg <= strobe_next;
            cbyte_reg <= cbyte_next;
            busy_reg <= busy_next;
        end
    end

    // Working copies: cleared by reset, then the backed-up ones refilled from flash
    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            for (int i = 0; i < NUM_REGS; i++)
            begin
                work_mem[i] <= WORK_RESET;
            end
        end
        else if (work_we)
        begin
            work_mem[work_wa] <= work_wd;
        end
    end

    // Nonvolatile store has no reset on purpose
    always_ff @(posedge clk_in)
    begin
        if (flash_we)
        begin
            flash_mem[flash_wa] <= flash_wd;
        end
    end

    assign link.miso = miso_reg;
    assign link.miso_oe_n = oe_n_reg;
    assign cfg_loaded_out = loaded_reg;
    assign flash_busy_out = busy_reg;
    assign cmd_strobe_out = strobe_reg;
    assign cmd_byte_out = cbyte_reg;
endmodule : srpfb_dev

// ==== common/srpfb_pkg.sv ====
// Shared constants for the serial register port with flash backup
// How it works
// - Port acts only while chip select low.
// - Input bits captured on serial clock rise.
// - Output bits change on serial clock fall.
// - Output driven only while chip select low.
// - 16-bit registers, upper and lower byte addresses.
// - Output returns register named by earlier read.
// - Host waits gap after 16th edge.
// - Host traffic uses working copies, flash backs some.
// - Flash saved only by a command write to 0x3e with bit 6 set.
// - Reset reloads backed-up working registers from flash, clears the rest.
// - Read takes two frames, second returns data.
// - Mode 3 master, MSB first, 16-bit frames.
// - Each write frame outside a load or save, except to 0x3e, updates one byte.
// - Write actions fire at 16th rising edge.
package srpfb_pkg;
    localparam int FRAME_BITS = 16;
    localparam int DIR_BIT = 15;
    localparam int ADDR_MSB = 14;
    localparam int ADDR_LSB = 8;
    localparam int DATA_MSB = 7;
    localparam int NUM_REGS = 64;
    localparam logic [6:0] CMD_ADDR = 7'h3e;
    localparam int FLASH_UPD_BIT = 6;
    localparam logic [5:0] FLASH_CNT_REG = 6'h00;
    localparam logic [63:0] FLASH_BACKUP_MASK = 64'h0000_0000_0300_e0cf;
    localparam logic [15:0] WORK_RESET = 16'h0000;
    localparam logic [15:0] BUSY_WORD = 16'h0000;
    localparam logic [2:0] PIN_IDLE = 3'h3;
    localparam int PIN_SCLK = 0;
    localparam int PIN_CS = 1;
    localparam int PIN_DATA = 2;
    localparam int CLK_PERIOD_PS = 10000;
    localparam int GAP_PS = 16500000;
    localparam int GAP_CYC = (GAP_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int SCLK_MIN_PERIOD_PS = 400000;
    localparam int SCLK_HALF_CYC = (SCLK_MIN_PERIOD_PS / 2 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
    localparam int CS_LEAD_PS = 48800;
    localparam int CS_LEAD_CYC = (CS_LEAD_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
endpackage : srpfb_pkg

// ==== common/srpfb_link_if.sv ====
// Four-wire serial link between host and device
`timescale 1ns/1ns
interface srpfb_link_if;
    logic sclk;
    logic cs_n;
    logic mosi;
    logic miso;
    logic miso_oe_n;
    logic miso_line;
    // Released line reads as pulled high
    assign miso_line = miso_oe_n ? 1'b1 : miso;
    modport dev (input sclk, input cs_n, input mosi, output miso, output miso_oe_n);
    modport host (output sclk, output cs_n, output mosi, input miso_line);
endinterface : srpfb_link_if

// ==== hw/srpfb_host.sv ====
// Host end: mode 3 serial master with word request and response
`timescale 1ns/1ns
module srpfb_host
    import srpfb_pkg::*;
#(
    parameter int HALF_CYC = SCLK_HALF_CYC,
    parameter int LEAD_CYC = CS_LEAD_CYC,
    parameter int GAP_CYCLES = GAP_CYC
)
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Serial link
    srpfb_link_if.host link,
    // Word request
    input wire logic req_valid_in,
    input wire logic [15:0] req_word_in,
    output logic req_ready_out,
    // Word response
    output logic resp_valid_out,
    output logic [15:0] resp_word_out
);
    typedef enum logic [2:0] {H_IDLE, H_LEAD, H_LOW, H_HIGH, H_TAIL, H_GAP} srpfb_hstate_t;

    // A low phase must outlast the trip through both pin filters and back
    if (HALF_CYC < 9 || LEAD_CYC < 1 || GAP_CYCLES < 1 || GAP_CYCLES > 65535
        || HALF_CYC > 65535 || LEAD_CYC > 65535)
    begin : g_bad_timing
        $error("srpfb_host: timing parameter out of range");
    end

    srpfb_hstate_t st_reg, st_next;
    logic [2:0] sy_reg, sy_next;
    logic flt_reg, flt_next;
    logic [15:0] tmr_reg, tmr_next, gap_reg, gap_next;
    logic [15:0] sh_reg, sh_next, rx_reg, rx_next;
    logic [3:0] bit_reg, bit_next;
    logic sclk_reg, sclk_next, cs_n_reg, cs_n_next, mosi_reg, mosi_next;
    logic rdy_reg, rdy_next, rv_reg, rv_next;
    logic [15:0] rw_reg, rw_next;

    always_comb
    begin
        sy_next = {sy_reg[1:0], link.miso_line};
        flt_next = (sy_reg[1] == sy_reg[2]) ? sy_reg[2] : flt_reg;
        st_next = st_reg;
        tmr_next = (tmr_reg != 16'h0000) ? tmr_reg - 16'h0001 : tmr_reg;
        gap_next = (gap_reg != 16'h0000) ? gap_reg - 16'h0001 : gap_reg;
        sh_next = sh_reg;
        rx_next = rx_reg;
        bit_next = bit_reg;
        sclk_next = sclk_reg;
        cs_n_next = cs_n_reg;
        mosi_next = mosi_reg;
        rdy_next = 1'b0;
        rv_next = 1'b0;
        rw_next = rw_reg;
        unique case (st_reg)
            H_IDLE:
            begin
                rdy_next = 1'b1;
                if (req_valid_in && rdy_reg)
                begin
                    rdy_next = 1'b0;
                    sh_next = req_word_in;
                    cs_n_next = 1'b0;
                    tmr_next = 16'(LEAD_CYC - 1);
                    st_next = H_LEAD;
                end
            end
            H_LEAD, H_HIGH:
            begin
                if (tmr_reg == 16'h0000)
                begin
                    if (st_reg == H_HIGH && bit_reg == 4'(FRAME_BITS - 1))
                    begin
                        tmr_next = 16'(LEAD_CYC - 1);
                        st_next = H_TAIL;
                    end
                    else
                    begin
                        // Data changes on the falling edge, MSB first
                        sclk_next = 1'b0;
                        mosi_next = sh_reg[15];
                        sh_next = {sh_reg[14:0], 1'b0};
                        bit_next = (st_reg == H_LEAD) ? 4'h0 : bit_reg + 4'h1;
                        tmr_next = 16'(HALF_CYC - 1);
                        st_next = H_LOW;
                    end
                end
            end
            H_LOW:
            begin
                if (tmr_reg == 16'h0000)
                begin
                    sclk_next = 1'b1;
                    rx_next = {rx_reg[14:0], flt_reg};
                    tmr_next = 16'(HALF_CYC - 1);
                    st_next = H_HIGH;
                    if (bit_reg == 4'(FRAME_BITS - 1))
                    begin
                        // Idle gap runs from the 16th rising edge
                        gap_next = 16'(GAP_CYCLES - 1);
                        rv_next = 1'b1;
                        rw_next = {rx_reg[14:0], flt_reg};
                    end
                end
            end
            H_TAIL:
            begin
                if (tmr_reg == 16'h0000)
                begin
                    cs_n_next = 1'b1;
                    st_next = H_GAP;
                end
            end
            H_GAP:
            begin
                if (gap_reg == 16'h0000)
                begin
                    st_next = H_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            st_reg <= H_IDLE;
            sy_reg <= 3'h7;
            flt_reg <= 1'b1;
            tmr_reg <= 16'h0000;
            gap_reg <= 16'h0000;
            sh_reg <= 16'h0000;
            rx_reg <= 16'h0000;
            bit_reg <= 4'h0;
            sclk_reg <= 1'b1;
            cs_n_reg <= 1'b1;
            mosi_reg <= 1'b1;
            rdy_reg <= 1'b0;
            rv_reg <= 1'b0;
            rw_reg <= 16'h0000;
        end
        else
        begin
            st_reg <= st_next;
            sy_reg <= sy_next;
            flt_reg <= flt_next;
            tmr_reg <= tmr_next;
            gap_reg <= gap_next;
            sh_reg <= sh_next;
            rx_reg <= rx_next;
            bit_reg <= bit_next;
            sclk_reg <= sclk_next;
            cs_n_reg <= cs_n_next;
            mosi_reg <= mosi_next;
            rdy_reg <= rdy_next;
            rv_reg <= rv_next;
            rw_reg <= rw_next;
        end
    end

    assign link.sclk = sclk_reg;
    assign link.cs_n = cs_n_reg;
    assign link.mosi = mosi_reg;
    assign req_ready_out = rdy_reg;
    assign resp_valid_out = rv_reg;
    assign resp_word_out = rw_reg;
endmodule : srpfb_host

// ==== sim/srpfb_link_asserts.sv ====
// Protocol checks on the serial link between host and device ends
`timescale 1ns/1ns
module srpfb_link_asserts
    import srpfb_pkg::*;
#(
    parameter int GAP_CYCLES = GAP_CYC
)
(
    // Clock and reset
    input wire logic clk_in,
    input wire logic rst_in,
    // Link wires
    input wire logic sclk,
    input wire logic cs_n,
    input wire logic mosi,
    input wire logic miso,
    input wire logic miso_oe_n
);
    logic sclk_reg;
    logic [3:0] rise_reg, rise_next;
    logic [15:0] idle_reg, idle_next;

    // Idle count saturates so the first frame after reset is never flagged
    always_comb
    begin
        rise_next = rise_reg;
        idle_next = (idle_reg == 16'hffff) ? idle_reg : idle_reg + 16'h0001;
        if (sclk && !sclk_reg)
        begin
            rise_next = rise_reg + 4'h1;
            if (rise_reg == 4'hf)
                idle_next = 16'h0000;
        end
    end

    always_ff @(posedge clk_in or posedge rst_in)
    begin
        if (rst_in)
        begin
            sclk_reg <= 1'b1;
            rise_reg <= 4'h0;
            idle_reg <= 16'hffff;
        end
        else
        begin
            sclk_reg <= sclk;
            rise_reg <= rise_next;
            idle_reg <= idle_next;
        end
    end

    default clocking cb @(posedge clk_in);
    endclocking
    default disable iff (rst_in);

    chk_quiet_when_free: assert property (cs_n [*5] |-> miso_oe_n)
        else $error("data out driven while deselected");
    chk_drive_when_sel: assert property (!cs_n [*6] |-> !miso_oe_n)
        else $error("data out not driven while selected");
    chk_out_on_fall: assert property (!miso_oe_n && $changed(miso) |-> !$past(sclk, 2))
        else $error("data out changed away from a falling clock");
    chk_clock_idle_high: assert property (cs_n |-> sclk)
        else $error("serial clock low while deselected");
    chk_select_lead: assert property ($fell(cs_n) |-> sclk [*5])
        else $error("serial clock moved too soon after select");
    chk_din_hold: assert property ($rose(sclk) |-> $stable(mosi) ##1 $stable(mosi) [*4])
        else $error("data in moved around a rising clock");
    chk_word_gap: assert property ($fell(sclk) && rise_reg == 4'h0 |-> idle_reg >= GAP_CYCLES)
        else $error("next word began before the gap ran out");
    chk_whole_frames: assert property ($rose(cs_n) |-> rise_reg == 4'h0)
        else $error("select released inside a frame");
endmodule : srpfb_link_asserts

// ==== sim/tb_spi_register_port_flash_backup.sv ====
// Testbench: host end and device end joined over the serial link
`timescale 1ns/1ns
module tb_spi_register_port_flash_backup;
    // Shortened gap keeps the run short; the checker gets the same value
    localparam int GAP = 50;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic req_valid = 1'b0;
    logic [15:0] req_word = 16'h0000;
    logic req_ready, resp_valid, cfg_loaded, flash_busy, cmd_strobe;
    logic [15:0] resp_word, r;
    logic [15:0] mosi_sh = 16'h0000;
    logic [15:0] miso_sh = 16'h0000;
    logic [7:0] cmd_byte;
    logic sclk_q = 1'b1;
    int mismatches = 0;
    int compares = 0;
    int strobes = 0;

    always #5 clk = ~clk;

    srpfb_link_if link ();

    srpfb_dev i_srpfb_dev (.clk_in(clk), .rst_in(rst), .link(link.dev),
        .cfg_loaded_out(cfg_loaded), .flash_busy_out(flash_busy),
        .cmd_strobe_out(cmd_strobe), .cmd_byte_out(cmd_byte));

    srpfb_host #(.HALF_CYC(10), .LEAD_CYC(5), .GAP_CYCLES(GAP)) i_srpfb_host (.clk_in(clk),
        .rst_in(rst), .link(link.host), .req_valid_in(req_valid), .req_word_in(req_word),
        .req_ready_out(req_ready), .resp_valid_out(resp_valid), .resp_word_out(resp_word));

    srpfb_link_asserts #(.GAP_CYCLES(GAP)) i_srpfb_link_asserts (.clk_in(clk), .rst_in(rst),
        .sclk(link.sclk), .cs_n(link.cs_n), .mosi(link.mosi), .miso(link.miso),
        .miso_oe_n(link.miso_oe_n));

    // Independent sniffer of both data wires at each rising serial clock
    always @(posedge clk)
    begin
        sclk_q <= link.sclk;
        if (link.sclk && !sclk_q && !link.cs_n)
        begin
            mosi_sh <= {mosi_sh[14:0], link.mosi};
            miso_sh <= {miso_sh[14:0], link.miso_line};
        end
        if (cmd_strobe === 1'b1)
            strobes <= strobes + 1;
    end

    task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        compares++;
        if (seen !== exp)
        begin
            mismatches++;
            $display("BAD %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic finish_test();
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : finish_test

    task automatic frame(input logic [15:0] word);
        int n;
        @(posedge clk);
        #1;
        req_valid = 1'b1;
        req_word = word;
        n = 0;
        while (req_ready !== 1'b1 && n < 5000)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        @(posedge clk);
        #1;
        req_valid = 1'b0;
        n = 0;
        while (resp_valid !== 1'b1 && n < 1000)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        r = resp_word;
        check("resp", {15'h0000, resp_valid}, 16'h0001);
        // The sniffer takes the last bit one clock after the response pulse
        @(posedge clk);
        #1;
        check("mosi wire", mosi_sh, word);
        check("miso wire", miso_sh, r);
    endtask : frame

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        frame({1'b1, a, d});
    endtask : wr

    // Read costs two frames; the second one returns the data
    task automatic rd(input logic [6:0] a, input logic [15:0] exp);
        frame({1'b0, a, 8'h00});
        frame(16'h0000);
        check("read", r, exp);
    endtask : rd

    task automatic do_reset();
        int n;
        @(posedge clk);
        #1;
        rst = 1'b1;
        repeat (12) @(posedge clk);
        check("busy in reset", {15'h0000, flash_busy}, 16'h0001);
        check("loaded in reset", {15'h0000, cfg_loaded}, 16'h0000);
        check("oe in reset", {15'h0000, link.miso_oe_n}, 16'h0001);
        #1;
        rst = 1'b0;
        n = 0;
        while (cfg_loaded !== 1'b1 && n < 200)
        begin
            @(posedge clk);
            #1;
            n++;
        end
        check("loaded", {15'h0000, cfg_loaded}, 16'h0001);
        check("busy", {15'h0000, flash_busy}, 16'h0000);
    endtask : do_reset

    initial
    begin
        repeat (20000) @(posedge clk);
        mismatches++;
        finish_test();
    end

    initial
    begin
        do_reset();
        wr(7'h04, 8'h5a);
        wr(7'h05, 8'hc3);
        wr(7'h22, 8'h77);
        rd(7'h04, 16'hc35a);
        rd(7'h05, 16'hc35a);
        rd(7'h22, 16'h0077);
        check("strobes", strobes[15:0], 16'h0000);
        wr(7'h3e, 8'h40);
        // The last edge reaches the device through its pin filter a few clocks later
        repeat (6) @(posedge clk);
        #1;
        check("saving", {15'h0000, flash_busy}, 16'h0001);
        check("strobes", strobes[15:0], 16'h0001);
        check("cmd byte", {8'h00, cmd_byte}, 16'h0040);
        // Frames during the save are ignored, so wait for it to end
        repeat (200)
        begin
            if (flash_busy === 1'b1)
                @(posedge clk);
        end
        #1;
        check("saved", {15'h0000, flash_busy}, 16'h0000);
        rd(7'h00, 16'h0001);
        wr(7'h04, 8'h11);
        rd(7'h04, 16'hc311);
        do_reset();
        rd(7'h04, 16'hc35a);
        rd(7'h22, 16'h0000);
        rd(7'h00, 16'h0001);
        finish_test();
    end
endmodule : tb_spi_register_port_flash_backup
